/* File: design/ctge_defs.svh */
`ifndef CTGE_DEFS_SVH
`define CTGE_DEFS_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define CTGE_ADDR_W 18
`define CTGE_IDX_CONTROL 16'h0001
`define CTGE_IDX_STATUS 16'h0002
`define CTGE_IDX_OR_MASK 16'h9e0c
`define CTGE_IDX_MODE 16'h9ea2
`define CTGE_IDX_LEVEL0 16'ha4d8
`define CTGE_IDX_LEVEL1 16'ha53c
`define CTGE_IDX_PULSE 16'hac45

// ***************************************************************
// reset values
// ***************************************************************
`define CTGE_RST_CONTROL 32'h00000000
`define CTGE_RST_OR_MASK 32'h00000000
`define CTGE_RST_MODE 32'h00000000
`define CTGE_RST_LEVEL 32'h00000000
`define CTGE_RST_PULSE 32'h00000000

// ***************************************************************
// field positions
// ***************************************************************
`define CTGE_MASK_CH0_BIT 0
`define CTGE_CTRL_RUN_BIT 0
`define CTGE_ST_GATE_BIT 0
`define CTGE_ST_ARMED_BIT 1
`define CTGE_ST_COUNT_BIT 2
`define CTGE_ST_RUN_BIT 3

// ***************************************************************
// mode codes and qualifier flags
// ***************************************************************
`define CTGE_MODE_RISE 32'h00000001
`define CTGE_MODE_FALL 32'h00000002
`define CTGE_MODE_ABOVE 32'h00000008
`define CTGE_MODE_BELOW 32'h00000010
`define CTGE_FLAG_ARM 32'h01000000
`define CTGE_FLAG_LONG 32'h04000000

// ***************************************************************
// pulse length floor and bus responses
// ***************************************************************
`define CTGE_PW_MIN 16'h0002
`define CTGE_RESP_OKAY 2'h0
`define CTGE_RESP_SLVERR 2'h2

`endif

/* File: design/ctge_pkg.sv */
// ***************************************************************
// shared types
// ***************************************************************
package ctge_pkg;
    // decoded trigger mode
    typedef enum logic [2:0] {
        CTGE_OFF,
        CTGE_RISE,
        CTGE_FALL,
        CTGE_ABOVE,
        CTGE_BELOW,
        CTGE_RISE_ARM,
        CTGE_FALL_ARM,
        CTGE_RISE_LONG
    } ctge_kind_e;
endpackage

/* File: design/ctge_cross.sv */
`timescale 1ns/1ps

// ***************************************************************
// level crossing detector
// ***************************************************************
module ctge_cross #(
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic clear,
    input wire logic strobe,
    // sample and level
    input wire logic signed [SAMPLE_W-1:0] sample,
    input wire logic signed [SAMPLE_W-1:0] level,
    // one-sample crossing events
    output logic up,
    output logic down
);
    typedef struct packed {
        logic have_prev;
        logic prev_above;
    } ctge_cross_s;

    ctge_cross_s s;
    ctge_cross_s next_s;
    logic above;

    // compare current sample with the previous one against the level
    always_comb begin
        above = (sample >= level);
        up = strobe && s.have_prev && !s.prev_above && above;
        down = strobe && s.have_prev && s.prev_above && !above;
        next_s = s;
        if (clear) begin
            next_s.have_prev = 1'b0;
            next_s.prev_above = 1'b0;
        end else if (strobe) begin
            next_s.have_prev = 1'b1;
            next_s.prev_above = above;
        end
    end

    // history register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

/* File: design/ctge_top.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ctge_defs.svh"

// Function
// - compare every sample against programmed levels
// - rising mode opens gate on upward crossing
// - rising mode closes gate on downward crossing
// - edge modes ignore level present at start
// - above mode gate follows sample at least level
// - level modes open immediately at start
// - falling mode opens down, closes up
// - below mode gate follows sample at most level
// - rising arm mode arms on secondary upcross
// - armed upcross opens and disarms, downcross closes
// - falling arm mode arms on secondary downcross
// - armed downcross opens and disarms, upcross closes
// - disarmed engine ignores opening trigger crossings, a closing one still closes
// - secondary level arms, primary level triggers
// - long pulse counts from upcross, early downcross cancels
// - long pulse opens at count, closes downcross
module ctge_top #(
    parameter int SAMPLE_W = 16,
    parameter int PW_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [`CTGE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [`CTGE_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sample stream on aclk
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_data,
    // gate and engine state
    output logic gate_open,
    output logic gate_armed
);
    import ctge_pkg::*;

    // ***************************************************************
    // parameter checks
    // ***************************************************************
    if (SAMPLE_W < 2 || SAMPLE_W > 32) begin : g_bad_sample_w
        $error("sample width must be 2 to 32");
    end
    if (PW_W < 2 || PW_W > 16) begin : g_bad_pw_w
        $error("pulse counter width must be 2 to 16");
    end

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        logic [31:0] or_mask;
        logic [31:0] mode;
        logic [31:0] level_primary;
        logic [31:0] level_secondary;
        logic [31:0] pulse_len;
        logic run;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [`CTGE_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic gate;
        logic armed;
        logic counting;
        logic [PW_W-1:0] cnt;
    } ctge_state_s;

    ctge_state_s s;
    ctge_state_s next_s;

    logic live;
    logic strobe;
    logic clear;
    logic trig_up;
    logic trig_down;
    logic arm_up;
    logic arm_down;
    logic at_least;
    logic at_most;
    logic signed [SAMPLE_W-1:0] lvl_trig;
    logic signed [SAMPLE_W-1:0] lvl_arm;
    logic [PW_W-1:0] pw_eff;
    ctge_kind_e kind;

    // ***************************************************************
    // helpers
    // ***************************************************************
    // base code combined with qualifier flags
    function automatic ctge_kind_e kind_of(input logic [31:0] m);
        ctge_kind_e k;
        k = CTGE_OFF;
        case (m)
            `CTGE_MODE_RISE: k = CTGE_RISE;
            `CTGE_MODE_FALL: k = CTGE_FALL;
            `CTGE_MODE_ABOVE: k = CTGE_ABOVE;
            `CTGE_MODE_BELOW: k = CTGE_BELOW;
            (`CTGE_MODE_RISE | `CTGE_FLAG_ARM): k = CTGE_RISE_ARM;
            (`CTGE_MODE_FALL | `CTGE_FLAG_ARM): k = CTGE_FALL_ARM;
            (`CTGE_MODE_RISE | `CTGE_FLAG_LONG): k = CTGE_RISE_LONG;
            default: k = CTGE_OFF;
        endcase
        return k;
    endfunction

    // byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ***************************************************************
    // mode decode and level compare
    // ***************************************************************
    // engine runs only with the channel in the mask and run set
    assign kind = kind_of(s.mode);
    assign live = s.run && s.or_mask[`CTGE_MASK_CH0_BIT];
    assign strobe = live && sample_valid;
    assign clear = !live;
    assign lvl_trig = s.level_primary[SAMPLE_W-1:0];
    assign lvl_arm = s.level_secondary[SAMPLE_W-1:0];
    assign at_least = (sample_data >= lvl_trig);
    assign at_most = (sample_data <= lvl_trig);
    assign pw_eff = (s.pulse_len[PW_W-1:0] < PW_W'(`CTGE_PW_MIN)) ?
                    PW_W'(`CTGE_PW_MIN) : s.pulse_len[PW_W-1:0];

    // crossings of the trigger level
    ctge_cross #(
        .SAMPLE_W(SAMPLE_W)
    ) u_trig_cross (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(clear),
        .strobe(strobe),
        .sample(sample_data),
        .level(lvl_trig),
        .up(trig_up),
        .down(trig_down)
    );

    // crossings of the arming level
    ctge_cross #(
        .SAMPLE_W(SAMPLE_W)
    ) u_arm_cross (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(clear),
        .strobe(strobe),
        .sample(sample_data),
        .level(lvl_arm),
        .up(arm_up),
        .down(arm_down)
    );

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        next_s = s;

        // write address and data are taken independently
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_have = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // perform the write once both halves are held
        if (s.aw_have && s.w_have && !s.bvalid) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `CTGE_RESP_OKAY;
            case (s.awaddr[`CTGE_ADDR_W-1:2])
                `CTGE_IDX_CONTROL: begin
                    next_s.run = s.wstrb[`CTGE_CTRL_RUN_BIT / 8] ? s.wdata[`CTGE_CTRL_RUN_BIT] : s.run;
                end
                `CTGE_IDX_OR_MASK: next_s.or_mask = merge(s.or_mask, s.wdata, s.wstrb);
                `CTGE_IDX_MODE: next_s.mode = merge(s.mode, s.wdata, s.wstrb);
                `CTGE_IDX_LEVEL0: next_s.level_primary = merge(s.level_primary, s.wdata, s.wstrb);
                `CTGE_IDX_LEVEL1: next_s.level_secondary = merge(s.level_secondary, s.wdata, s.wstrb);
                `CTGE_IDX_PULSE: next_s.pulse_len = merge(s.pulse_len, s.wdata, s.wstrb);
                `CTGE_IDX_STATUS: next_s.bresp = `CTGE_RESP_OKAY; // read-only, write ignored
                default: next_s.bresp = `CTGE_RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_have;
        next_s.wready = !next_s.w_have;

        // read path: data registered at the accepting edge
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `CTGE_RESP_OKAY;
            next_s.rdata = 32'h00000000;
            case (s_axi_araddr[`CTGE_ADDR_W-1:2])
                `CTGE_IDX_CONTROL: next_s.rdata[`CTGE_CTRL_RUN_BIT] = s.run;
                `CTGE_IDX_STATUS: begin
                    next_s.rdata[`CTGE_ST_GATE_BIT] = s.gate;
                    next_s.rdata[`CTGE_ST_ARMED_BIT] = s.armed;
                    next_s.rdata[`CTGE_ST_COUNT_BIT] = s.counting;
                    next_s.rdata[`CTGE_ST_RUN_BIT] = s.run;
                end
                `CTGE_IDX_OR_MASK: next_s.rdata = s.or_mask;
                `CTGE_IDX_MODE: next_s.rdata = s.mode;
                `CTGE_IDX_LEVEL0: next_s.rdata = s.level_primary;
                `CTGE_IDX_LEVEL1: next_s.rdata = s.level_secondary;
                `CTGE_IDX_PULSE: next_s.rdata = s.pulse_len;
                default: next_s.rresp = `CTGE_RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // trigger engine, one step per sample
        if (!live) begin
            next_s.gate = 1'b0;
            next_s.armed = 1'b0;
            next_s.counting = 1'b0;
            next_s.cnt = '0;
        end else if (sample_valid) begin
            case (kind)
                CTGE_RISE: begin
                    if (trig_up) begin
                        next_s.gate = 1'b1;
                    end else if (trig_down) begin
                        next_s.gate = 1'b0;
                    end
                end
                CTGE_FALL: begin
                    if (trig_down) begin
                        next_s.gate = 1'b1;
                    end else if (trig_up) begin
                        next_s.gate = 1'b0;
                    end
                end
                CTGE_ABOVE: begin
                    next_s.gate = at_least;
                end
                CTGE_BELOW: begin
                    next_s.gate = at_most;
                end
                CTGE_RISE_ARM: begin
                    if (s.armed && trig_up) begin
                        next_s.gate = 1'b1;
                    end else if (trig_down) begin
                        next_s.gate = 1'b0;
                    end
                    // a new arming crossing wins over the disarm
                    next_s.armed = arm_up || (s.armed && !trig_up);
                end
                CTGE_FALL_ARM: begin
                    if (s.armed && trig_down) begin
                        next_s.gate = 1'b1;
                    end else if (trig_up) begin
                        next_s.gate = 1'b0;
                    end
                    next_s.armed = arm_down || (s.armed && !trig_down);
                end
                CTGE_RISE_LONG: begin
                    if (trig_down) begin
                        next_s.gate = 1'b0;
                        next_s.counting = 1'b0;
                        next_s.cnt = '0;
                    end else if (trig_up && !s.gate) begin
                        next_s.counting = 1'b1;
                        next_s.cnt = PW_W'(1);
                    end else if (s.counting) begin
                        if (s.cnt + PW_W'(1) >= pw_eff) begin
                            next_s.gate = 1'b1;
                            next_s.counting = 1'b0;
                            next_s.cnt = '0;
                        end else begin
                            next_s.cnt = s.cnt + PW_W'(1);
                        end
                    end
                end
                default: begin
                    next_s.gate = 1'b0;
                    next_s.armed = 1'b0;
                    next_s.counting = 1'b0;
                    next_s.cnt = '0;
                end
            endcase
        end
    end

    // ***************************************************************
    // state register
    // ***************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.or_mask <= `CTGE_RST_OR_MASK;
            s.mode <= `CTGE_RST_MODE;
            s.level_primary <= `CTGE_RST_LEVEL;
            s.level_secondary <= `CTGE_RST_LEVEL;
            s.pulse_len <= `CTGE_RST_PULSE;
            s.run <= 1'(`CTGE_RST_CONTROL >> `CTGE_CTRL_RUN_BIT);
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ***************************************************************
    // outputs straight from the state register
    // ***************************************************************
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign gate_open = s.gate;
    assign gate_armed = s.armed;
endmodule

/* File: sim/ctge_top_monitor.sv */
`timescale 1ns/1ps

// ********
// bus and gate checker
// ********
module ctge_top_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sample stream and gate
    input wire logic sample_valid,
    input wire logic gate_open,
    input wire logic gate_armed
);
    // one clock domain, reset disables all checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // bus answers stand until taken
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    a_b_follows: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && s_axi_awready && s_axi_wready)
        else $error("write response without taken request");
    a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("illegal write response code");
    // gate and arming move only on a sample or a stop
    a_gate_opens: assert property ($rose(gate_open) |-> $past(sample_valid))
        else $error("gate opened without a sample");
    a_gate_moves: assert property ($changed(gate_open) |-> $past(sample_valid) || $past(s_axi_bvalid))
        else $error("gate changed without cause");
    a_arm_rises: assert property ($rose(gate_armed) |-> $past(sample_valid))
        else $error("engine armed without a sample");
endmodule

bind ctge_top ctge_top_monitor u_mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .sample_valid, .gate_open, .gate_armed);

/* File: sim/ctge_sample_src.sv */
`timescale 1ns/1ps

// ********
// adc sample source
// ********
module ctge_sample_src (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request from the bench
    input wire logic push,
    input wire logic signed [15:0] value,
    // sample stream
    output logic sample_valid,
    output logic signed [15:0] sample_data
);
    // one strobe per sample, data scrambled between samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_valid <= 1'b0;
            sample_data <= 16'h5a5a;
        end else begin
            sample_valid <= push;
            sample_data <= push ? value : ~sample_data;
        end
    end
endmodule

/* File: sim/test_channel_trigger_gate_engine.sv */
`timescale 1ns/1ps
`include "ctge_defs.svh"

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end

// ********
// self-checking bench
// ********
module test_channel_trigger_gate_engine;
    // clock, reset and bus master signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [17:0] s_axi_awaddr = '0;
    logic [17:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // sample stream, gate and reference state
    logic sample_valid, gate_open, gate_armed;
    logic push = 1'b0;
    logic signed [15:0] sample_data;
    logic signed [15:0] value = '0;
    logic signed [15:0] pv;
    bit hp, eg, ea;
    int cnt;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] modes[8] = '{`CTGE_MODE_RISE, `CTGE_MODE_FALL, `CTGE_MODE_ABOVE, `CTGE_MODE_BELOW,
        `CTGE_FLAG_ARM | `CTGE_MODE_RISE, `CTGE_FLAG_ARM | `CTGE_MODE_FALL, `CTGE_FLAG_LONG | `CTGE_MODE_RISE, 32'h3};
    logic [15:0] regs[6] = '{`CTGE_IDX_OR_MASK, `CTGE_IDX_MODE, `CTGE_IDX_LEVEL0, `CTGE_IDX_LEVEL1,
        `CTGE_IDX_PULSE, `CTGE_IDX_CONTROL};

    // free-running 100 MHz clock
    always #5 aclk = ~aclk;

    // design and adc source
    ctge_top uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_data, .gate_open, .gate_armed
    );
    ctge_sample_src src (.aclk, .aresetn, .push, .value, .sample_valid, .sample_data);

    // closing report
    task automatic print_verdict;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bounded wait ran out
    task automatic hang;
        num_errors++;
        $display("unexpected handshake: expected answer, seen none");
        print_verdict();
    endtask

    // register write, address and data offered together
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic a, w, b, v;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom_range(0, 1)); // late ready makes the slave hold its answer
        repeat (50) begin
            @(negedge aclk);
            a = s_axi_awready & s_axi_awvalid;
            w = s_axi_wready & s_axi_wvalid;
            v = s_axi_bvalid;
            b = v & s_axi_bready;
            if (b) `CHK("bresp", er, s_axi_bresp)
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                return;
            end
            if (v) s_axi_bready <= 1'b1;
        end
        hang();
    endtask

    // register read, data compared under a mask
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed, m, input logic [1:0] er);
        logic a, r, v;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(0, 1)); // late ready makes the slave hold its answer
        repeat (50) begin
            @(negedge aclk);
            a = s_axi_arready & s_axi_arvalid;
            v = s_axi_rvalid;
            r = v & s_axi_rready;
            if (r) `CHK("rdata", ed & m, s_axi_rdata & m)
            if (r) `CHK("rresp", er, s_axi_rresp)
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'b0;
            if (r) begin
                s_axi_rready <= 1'b0;
                return;
            end
            if (v) s_axi_rready <= 1'b1;
        end
        hang();
    endtask

    // one sample through the source, random spacing, result settled
    task automatic smp(input logic signed [15:0] s);
        @(posedge aclk);
        push <= 1'b1;
        value <= s;
        @(posedge aclk);
        push <= 1'b0;
        repeat (1 + $urandom_range(0, 2)) @(posedge aclk);
        @(negedge aclk);
    endtask

    // reference engine, one sample
    function automatic void step(logic [31:0] m, logic signed [15:0] s, l0, l1, int pw);
        bit u, d, u1, d1;
        u = hp && pv < l0 && s >= l0;
        d = hp && pv >= l0 && s < l0;
        u1 = hp && pv < l1 && s >= l1;
        d1 = hp && pv >= l1 && s < l1;
        case (m)
            `CTGE_MODE_RISE: eg = u | (eg & ~d);
            `CTGE_MODE_FALL: eg = d | (eg & ~u);
            `CTGE_MODE_ABOVE: eg = s >= l0;
            `CTGE_MODE_BELOW: eg = s <= l0;
            `CTGE_FLAG_ARM | `CTGE_MODE_RISE: begin
                eg = (u & ea) | (eg & ~d);
                ea = u1 | (ea & ~u);
            end
            `CTGE_FLAG_ARM | `CTGE_MODE_FALL: begin
                eg = (d & ea) | (eg & ~u);
                ea = d1 | (ea & ~d);
            end
            `CTGE_FLAG_LONG | `CTGE_MODE_RISE: begin
                cnt = d ? 0 : (u && !eg) ? 1 : (cnt > 0) ? cnt + 1 : 0;
                eg = (cnt >= pw) | (eg & ~d);
                if (cnt >= pw) cnt = 0;
            end
            default: eg = 0;
        endcase
        pv = s;
        hp = 1;
    endfunction

    // configure, start, stream samples, stop
    task automatic run_mode(input logic [31:0] m, input logic msk, input int n);
        logic signed [15:0] l0, l1, s;
        int pw;
        l0 = 16'(int'($urandom_range(0, 60)) - 30);
        l1 = 16'(int'(l0) + int'($urandom_range(0, 8)) - 4);
        pw = $urandom_range(2, 5);
        wr(`CTGE_IDX_OR_MASK, {31'h0, msk}, `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_MODE, m, `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_LEVEL0, 32'(l0), `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_LEVEL1, 32'(l1), `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_PULSE, 32'(pw), `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_CONTROL, 32'h1, `CTGE_RESP_OKAY);
        hp = 0;
        eg = 0;
        ea = 0;
        cnt = 0;
        for (int i = 0; i < n; i++) begin
            s = (i == 0) ? ((m[1] | m[4]) ? l0 - 16'sd3 : l0 + 16'sd3) : (i == 1) ? l0
                : 16'(int'(l0) + int'($urandom_range(0, 16)) - 8);
            smp(s);
            if (msk) step(m, s, l0, l1, pw);
            `CHK("gate_open", eg, gate_open)
            `CHK("gate_armed", ea, gate_armed)
        end
        rd(`CTGE_IDX_STATUS, {28'h0, 2'b10, ea, eg}, 32'hb, `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_CONTROL, 32'h0, `CTGE_RESP_OKAY);
        @(negedge aclk);
        `CHK("gate_open", 1'b0, gate_open)
    endtask

    // main sequence
    initial begin
        logic [31:0] d;
        d = $urandom(4);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) begin
            d = $urandom();
            rd(regs[i], 32'h0, '1, `CTGE_RESP_OKAY);
            wr(regs[i], d, `CTGE_RESP_OKAY);
            rd(regs[i], d, (i == 5) ? 32'h1 : '1, `CTGE_RESP_OKAY);
        end
        wr(`CTGE_IDX_CONTROL, 32'h0, `CTGE_RESP_OKAY);
        wr(`CTGE_IDX_STATUS, '1, `CTGE_RESP_OKAY);
        rd(`CTGE_IDX_STATUS, 32'h0, '1, `CTGE_RESP_OKAY);
        wr(16'h0003, '1, `CTGE_RESP_SLVERR);
        rd(16'h0003, 32'h0, '1, `CTGE_RESP_SLVERR);
        run_mode(`CTGE_MODE_ABOVE, 1'b0, 10);
        repeat (3) foreach (modes[i]) run_mode(modes[i], 1'b1, 50);
        print_verdict();
    end
endmodule
